// [logic/tlb_pkg.sv]
// constants and types shared by the task link busy tracker
// Function
// (R01) call/interrupt switch writes old record selector into new link, then sets nested flag
// (R02) interrupt return with nested flag 1 goes back to the task in link field
// (R03) jump switch does not nest: link unused, nested flag not forced
// (R04) new busy set on jump/call, must be clear first; unchanged on return, must be set
// (R05) old busy cleared on jump and return, kept set on call/interrupt
// (R06) new nested flag from record image on jump/return, forced set on call
// (R07) old nested flag cleared only on interrupt return
// (R08) old link never changed; new link unchanged on jump and return
// (R09) task switched flag set on every switch
// (R10) call/interrupt to busy task raises protection fault; return does not
// (R11) refuse switch to current task or any nested busy task; chain unbounded
// (R12) every busy read-modify-write is a locked memory access
// (R13) nested flag writable by software without privilege check
// (R14) software should initialise each link field to zero
// (R15) uniprocessor unlinking: mask interrupts, relink, clear busy flags, unmask
// (R16) multiprocessor unlinking locks record and descriptor together
// (R17) page directory base reloaded from incoming record on each switch
// (R18) paging off maps linear addresses straight to physical
// (R19) outgoing state saved on every successful switch, restored on resume
// (R20) cause code selects jump, call/interrupt or return updates
package tlb_pkg;
  localparam int         SEL_W        = 16;
  localparam int         ADDR_W       = 32;
  localparam int         DATA_W       = 32;
  // cause encodings
  localparam logic [1:0] CAUSE_JUMP   = 2'h0;
  localparam logic [1:0] CAUSE_CALL   = 2'h1;
  localparam logic [1:0] CAUSE_RETURN = 2'h2;
  // record field offsets (bytes from record base)
  localparam logic [ADDR_W-1:0] OFS_LINK  = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] OFS_PDB   = 32'h0000_001c;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 32'h0000_0024;
  // descriptor word holding the busy flag, and the busy, nested, switched and paging bit positions
  localparam logic [ADDR_W-1:0] OFS_DESC_HI = 32'h0000_0004;
  localparam int         BUSY_BIT     = 9;
  localparam int         NESTED_BIT   = 14;
  localparam int         TS_BIT       = 3;
  localparam int         PG_BIT       = 31;
  // reset values
  localparam logic [DATA_W-1:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] PDB_RST   = 32'h0000_0000;
  localparam logic [SEL_W-1:0]  SEL_RST   = 16'h0000;
  // fault codes
  localparam logic [1:0] FLT_NONE     = 2'h0;
  localparam logic [1:0] FLT_PROT     = 2'h1;
  localparam logic [1:0] FLT_REC      = 2'h2;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_RDNEW  = 9'h002,
    ST_WRNEW  = 9'h004,
    ST_RDOLD  = 9'h008,
    ST_WROLD  = 9'h010,
    ST_SAVE   = 9'h020,
    ST_LINK   = 9'h040,
    ST_LOAD   = 9'h080,
    ST_DONE   = 9'h100
  } tlb_state_t;
endpackage : tlb_pkg

// [logic/tlb_task_link_busy_tracker.sv]
// task linkage, busy flag and control flag updates for a hardware task switch
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module tlb_task_link_busy_tracker (
  input  wire logic                       CLK_SYS,
  input  wire logic                       RST_N,
  // switch request
  input  wire logic                       SW_REQ,
  input  wire logic [1:0]                 SW_CAUSE,
  input  wire logic [tlb_pkg::SEL_W-1:0]  SW_TARGET_SEL,
  input  wire logic [tlb_pkg::ADDR_W-1:0] SW_NEW_REC_BASE,
  input  wire logic [tlb_pkg::ADDR_W-1:0] SW_NEW_DESC_ADDR,
  input  wire logic [tlb_pkg::ADDR_W-1:0] SW_OLD_DESC_ADDR,
  input  wire logic [tlb_pkg::ADDR_W-1:0] SW_OLD_REC_BASE,
  input  wire logic [tlb_pkg::DATA_W-1:0] SW_SAVED_FLAGS,
  // software flag writes, paging enable and linear address
  input  wire logic                       NF_WR,
  input  wire logic                       NF_WDATA,
  input  wire logic                       TS_CLR,
  input  wire logic                       PG_EN,
  input  wire logic [tlb_pkg::ADDR_W-1:0] LIN_ADDR,
  // memory port
  output logic                            MEM_REQ,
  output logic                            MEM_WE,
  output logic                            MEM_LOCK,
  output logic [tlb_pkg::ADDR_W-1:0]      MEM_ADDR,
  output logic [tlb_pkg::DATA_W-1:0]      MEM_WDATA,
  input  wire logic                       MEM_ACK,
  input  wire logic [tlb_pkg::DATA_W-1:0] MEM_RDATA,
  // status
  output logic                            SW_DONE,
  output logic [1:0]                      SW_FAULT,
  output logic                            NESTED_TASK_FLAG,
  output logic                            TASK_SWITCHED_FLAG,
  output logic [tlb_pkg::SEL_W-1:0]       CUR_TASK_SEL,
  output logic [tlb_pkg::DATA_W-1:0]      PAGE_DIR_BASE,
  output logic [tlb_pkg::ADDR_W-1:0]      PHYS_ADDR,
  output logic                            PHYS_DIRECT
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    tlb_pkg::tlb_state_t              st;
    logic [1:0]                       cause;
    logic [tlb_pkg::SEL_W-1:0]        tgt;
    logic [tlb_pkg::SEL_W-1:0]        link;
    logic [tlb_pkg::ADDR_W-1:0]       nrec;
    logic [tlb_pkg::ADDR_W-1:0]       ndesc;
    logic [tlb_pkg::ADDR_W-1:0]       odesc;
    logic [tlb_pkg::ADDR_W-1:0]       orec;
    logic [tlb_pkg::DATA_W-1:0]       sflags;
    logic [tlb_pkg::DATA_W-1:0]       flags_img;
    logic [1:0]                       phase;
    logic                             req;
    logic                             we;
    logic                             lock;
    logic [tlb_pkg::ADDR_W-1:0]       addr;
    logic [tlb_pkg::DATA_W-1:0]       wdata;
    logic                             done;
    logic [1:0]                       fault;
    logic                             nt;
    logic                             ts;
    logic [tlb_pkg::SEL_W-1:0]        cur;
    logic [tlb_pkg::DATA_W-1:0]       pdb;
    logic [tlb_pkg::ADDR_W-1:0]       paddr;
    logic                             pdir;
  } tlb_regs_t;

  tlb_regs_t s_r;
  tlb_regs_t s_nxt;
  logic      pg_meta_r;
  logic      pg_sync_r;

  // ************************************************************
  // page enable synchroniser
  // ************************************************************
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pg_meta_r <= 1'b0;
      pg_sync_r <= 1'b0;
    end else begin
      pg_meta_r <= PG_EN;
      pg_sync_r <= pg_meta_r;
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    s_nxt.paddr = LIN_ADDR;                                  // [R18]
    s_nxt.pdir  = !pg_sync_r;                                // [R18]
    if (NF_WR && s_r.st == tlb_pkg::ST_IDLE) begin
      s_nxt.nt = NF_WDATA;                                   // [R13]
    end
    if (TS_CLR) begin
      s_nxt.ts = 1'b0;
    end
    unique case (s_r.st)
      tlb_pkg::ST_IDLE: begin
        if (SW_REQ) begin
          s_nxt.cause  = SW_CAUSE;                           // [R20]
          s_nxt.nrec   = SW_NEW_REC_BASE;
          s_nxt.ndesc  = SW_NEW_DESC_ADDR;
          s_nxt.odesc  = SW_OLD_DESC_ADDR;
          s_nxt.orec   = SW_OLD_REC_BASE;
          s_nxt.sflags = SW_SAVED_FLAGS;
          s_nxt.fault  = tlb_pkg::FLT_NONE;
          if (SW_CAUSE == tlb_pkg::CAUSE_RETURN) begin
            if (s_r.nt) begin
              s_nxt.tgt = s_r.link;                          // [R02]
            end else begin
              s_nxt.tgt = SW_TARGET_SEL;
            end
          end else begin
            s_nxt.tgt = SW_TARGET_SEL;
          end
          if (SW_CAUSE != tlb_pkg::CAUSE_RETURN && SW_TARGET_SEL == s_r.cur) begin
            s_nxt.fault = tlb_pkg::FLT_PROT;                 // [R11]
            s_nxt.done  = 1'b1;
          end else begin
            s_nxt.st    = tlb_pkg::ST_RDNEW;
            s_nxt.req   = 1'b1;
            s_nxt.we    = 1'b0;
            s_nxt.lock  = 1'b1;                              // [R12]
            s_nxt.addr  = SW_NEW_DESC_ADDR + tlb_pkg::OFS_DESC_HI;
          end
        end
      end
      tlb_pkg::ST_RDNEW: begin
        if (MEM_ACK) begin
          if (s_r.cause == tlb_pkg::CAUSE_RETURN) begin
            s_nxt.st   = tlb_pkg::ST_RDOLD;                  // [R04]
            s_nxt.addr = s_r.odesc + tlb_pkg::OFS_DESC_HI;
            if (!MEM_RDATA[tlb_pkg::BUSY_BIT]) begin
              s_nxt.fault = tlb_pkg::FLT_REC;                // [R04]
              s_nxt.st    = tlb_pkg::ST_IDLE;
              s_nxt.req   = 1'b0;
              s_nxt.lock  = 1'b0;
              s_nxt.done  = 1'b1;
            end
          end else if (MEM_RDATA[tlb_pkg::BUSY_BIT]) begin
            s_nxt.fault = tlb_pkg::FLT_PROT;                 // [R10] [R11]
            s_nxt.st    = tlb_pkg::ST_IDLE;
            s_nxt.req   = 1'b0;
            s_nxt.lock  = 1'b0;
            s_nxt.done  = 1'b1;
          end else begin
            s_nxt.st    = tlb_pkg::ST_WRNEW;
            s_nxt.we    = 1'b1;
            s_nxt.wdata = MEM_RDATA | (32'h0000_0001 << tlb_pkg::BUSY_BIT); // [R04]
          end
        end
      end
      tlb_pkg::ST_WRNEW: begin
        if (MEM_ACK) begin
          s_nxt.we = 1'b0;
          if (s_r.cause == tlb_pkg::CAUSE_JUMP) begin
            s_nxt.st   = tlb_pkg::ST_RDOLD;
            s_nxt.addr = s_r.odesc + tlb_pkg::OFS_DESC_HI;
          end else begin
            s_nxt.st   = tlb_pkg::ST_SAVE;                   // [R05]
            s_nxt.lock = 1'b0;
            s_nxt.we   = 1'b1;
            s_nxt.addr = s_r.orec + tlb_pkg::OFS_FLAGS;
            s_nxt.wdata = s_r.sflags;
          end
        end
      end
      tlb_pkg::ST_RDOLD: begin
        if (MEM_ACK) begin
          s_nxt.st    = tlb_pkg::ST_WROLD;
          s_nxt.we    = 1'b1;
          s_nxt.wdata = MEM_RDATA & ~(32'h0000_0001 << tlb_pkg::BUSY_BIT); // [R05]
        end
      end
      tlb_pkg::ST_WROLD: begin
        if (MEM_ACK) begin
          s_nxt.st    = tlb_pkg::ST_SAVE;
          s_nxt.lock  = 1'b0;
          s_nxt.addr  = s_r.orec + tlb_pkg::OFS_FLAGS;
          s_nxt.wdata = s_r.sflags;
          if (s_r.cause == tlb_pkg::CAUSE_RETURN) begin
            s_nxt.wdata = s_r.sflags & ~(32'h0000_0001 << tlb_pkg::NESTED_BIT); // [R07]
          end
        end
      end
      tlb_pkg::ST_SAVE: begin
        if (MEM_ACK) begin                                   // [R19]
          if (s_r.cause == tlb_pkg::CAUSE_CALL) begin
            s_nxt.st    = tlb_pkg::ST_LINK;
            s_nxt.addr  = s_r.nrec + tlb_pkg::OFS_LINK;
            s_nxt.wdata = {16'h0000, s_r.cur};               // [R01]
          end else begin
            s_nxt.st    = tlb_pkg::ST_LOAD;                  // [R03] [R08]
            s_nxt.we    = 1'b0;
            s_nxt.addr  = s_r.nrec + tlb_pkg::OFS_FLAGS;
          end
        end
      end
      tlb_pkg::ST_LINK: begin
        if (MEM_ACK) begin
          s_nxt.st   = tlb_pkg::ST_LOAD;
          s_nxt.we   = 1'b0;
          s_nxt.addr = s_r.nrec + tlb_pkg::OFS_FLAGS;
        end
      end
      tlb_pkg::ST_LOAD: begin
        if (MEM_ACK) begin
          if (s_r.phase == 2'h0) begin
            s_nxt.flags_img = MEM_RDATA;
            s_nxt.phase     = 2'h1;
            s_nxt.addr      = s_r.nrec + tlb_pkg::OFS_PDB;
          end else if (s_r.phase == 2'h1) begin
            s_nxt.pdb   = MEM_RDATA;                         // [R17]
            s_nxt.phase = 2'h2;
            s_nxt.addr  = s_r.nrec + tlb_pkg::OFS_LINK;
          end else begin
            s_nxt.phase = 2'h0;
            s_nxt.req   = 1'b0;
            s_nxt.st    = tlb_pkg::ST_DONE;
            s_nxt.cur   = s_r.tgt;
            s_nxt.link  = MEM_RDATA[tlb_pkg::SEL_W-1:0];     // [R02]
            if (s_r.cause == tlb_pkg::CAUSE_CALL) begin
              s_nxt.nt = 1'b1;                               // [R01] [R06]
            end else begin
              s_nxt.nt = s_r.flags_img[tlb_pkg::NESTED_BIT]; // [R06] [R03]
            end
          end
        end
      end
      tlb_pkg::ST_DONE: begin
        s_nxt.ts   = 1'b1;                                   // [R09]
        s_nxt.done = 1'b1;
        s_nxt.st   = tlb_pkg::ST_IDLE;
      end
      default: begin
        s_nxt.st  = tlb_pkg::ST_IDLE;
        s_nxt.req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s_r       <= '0;
      s_r.st    <= tlb_pkg::ST_IDLE;
      s_r.pdb   <= tlb_pkg::PDB_RST;
      s_r.cur   <= tlb_pkg::SEL_RST;
      s_r.tgt   <= tlb_pkg::SEL_RST;
      s_r.link  <= tlb_pkg::SEL_RST;
      s_r.pdir  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign MEM_REQ            = s_r.req;
  assign MEM_WE             = s_r.we;
  assign MEM_LOCK           = s_r.lock;
  assign MEM_ADDR           = s_r.addr;
  assign MEM_WDATA          = s_r.wdata;
  assign SW_DONE            = s_r.done;
  assign SW_FAULT           = s_r.fault;
  assign NESTED_TASK_FLAG   = s_r.nt;
  assign TASK_SWITCHED_FLAG = s_r.ts;
  assign CUR_TASK_SEL       = s_r.cur;
  assign PAGE_DIR_BASE      = s_r.pdb;
  assign PHYS_ADDR          = s_r.paddr;
  assign PHYS_DIRECT        = s_r.pdir;

endmodule : tlb_task_link_busy_tracker

// [bench/tlb_mem_model.sv]
// memory model holding task records and descriptors
`timescale 1ns/1ps
module tlb_mem_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        slow,
  output logic             ack,
  output logic [31:0]      rdata
);
  logic [31:0] mem [0:16383];
  logic [2:0]  wait_r;
  // link fields start at zero
  initial for (int i = 0; i < 16384; i++) mem[i] = 32'h0;
  // *******************************
  // one access per request, slow mode waits
  // *******************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      rdata <= 32'h0;
      wait_r <= 3'h0;
    end else if (ack || !req || (slow && wait_r != 3'h5)) begin
      ack <= 1'b0;
      rdata <= ~rdata;
      wait_r <= (ack || !req) ? 3'h0 : wait_r + 3'h1;
    end else begin
      ack <= 1'b1;
      wait_r <= 3'h0;
      if (we) mem[addr[15:2]] <= wdata;
      else rdata <= mem[addr[15:2]];
    end
  end
endmodule : tlb_mem_model

// [bench/tlb_properties.sv]
// port checker for the task link busy tracker
`timescale 1ns/1ps
module tlb_properties (
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  input wire logic [1:0]  SW_CAUSE,
  input wire logic [31:0] SW_NEW_REC_BASE,
  input wire logic [31:0] SW_OLD_REC_BASE,
  input wire logic [31:0] SW_NEW_DESC_ADDR,
  input wire logic [31:0] SW_OLD_DESC_ADDR,
  input wire logic [31:0] LIN_ADDR,
  input wire logic        MEM_REQ,
  input wire logic        MEM_WE,
  input wire logic        MEM_LOCK,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] MEM_WDATA,
  input wire logic        SW_DONE,
  input wire logic [1:0]  SW_FAULT,
  input wire logic        NESTED_TASK_FLAG,
  input wire logic        TASK_SWITCHED_FLAG,
  input wire logic [15:0] CUR_TASK_SEL,
  input wire logic [31:0] PHYS_ADDR,
  input wire logic        PHYS_DIRECT
);
  // *******************************
  // helper terms
  // *******************************
  logic [31:0] nb;
  logic [31:0] ob;
  logic        wr;
  logic        ok;
  assign nb = SW_NEW_DESC_ADDR + tlb_pkg::OFS_DESC_HI;
  assign ob = SW_OLD_DESC_ADDR + tlb_pkg::OFS_DESC_HI;
  assign wr = MEM_REQ && MEM_WE;
  assign ok = SW_DONE && SW_FAULT == tlb_pkg::FLT_NONE;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // *******************************
  // assertions
  // *******************************
  chk_ts_set: assert property (ok |-> TASK_SWITCHED_FLAG)
    else $error("switched flag low at switch end");
  chk_ts_cause: assert property ($rose(TASK_SWITCHED_FLAG) |-> ok)
    else $error("switched flag rose outside a switch");
  chk_call_nest: assert property (ok && SW_CAUSE == tlb_pkg::CAUSE_CALL |-> NESTED_TASK_FLAG)
    else $error("nested flag clear after call");
  chk_busy_lock: assert property (MEM_REQ && (MEM_ADDR == nb || MEM_ADDR == ob) |-> MEM_LOCK)
    else $error("busy word access not locked");
  chk_link_sel: assert property (wr && SW_CAUSE == tlb_pkg::CAUSE_CALL && MEM_ADDR == SW_NEW_REC_BASE
    |-> MEM_WDATA[15:0] == CUR_TASK_SEL) else $error("link field not old selector");
  chk_link_keep: assert property (wr && SW_CAUSE != tlb_pkg::CAUSE_CALL |-> MEM_ADDR != SW_NEW_REC_BASE)
    else $error("new link written without call");
  chk_old_link: assert property (wr |-> MEM_ADDR != SW_OLD_REC_BASE + tlb_pkg::OFS_LINK)
    else $error("old link written");
  chk_new_busy: assert property (wr && MEM_ADDR == nb |-> ##0 SW_CAUSE != 2'h2 && MEM_WDATA[9])
    else $error("bad new busy write");
  chk_old_busy: assert property (wr && MEM_ADDR == ob |-> SW_CAUSE != 2'h1 && !MEM_WDATA[9])
    else $error("bad old busy write");
  chk_phys_same: assert property (PHYS_DIRECT && $past(RST_N) |-> PHYS_ADDR == $past(LIN_ADDR))
    else $error("direct map differs");
  cover property (SW_DONE && SW_FAULT == tlb_pkg::FLT_PROT);
  cover property (ok && SW_CAUSE == tlb_pkg::CAUSE_RETURN);
  cover property (wr && MEM_LOCK);
  cover property (SW_DONE && SW_FAULT == tlb_pkg::FLT_REC);
endmodule : tlb_properties
bind tlb_task_link_busy_tracker tlb_properties u_chk (.*);

// [bench/testbench.sv]
// self-checking bench for the task link busy tracker
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t got %h exp %h", $time, a, b); end end
module testbench;
  localparam logic [31:0] BB = 32'h1 << tlb_pkg::BUSY_BIT;
  localparam logic [31:0] NB = 32'h1 << tlb_pkg::NESTED_BIT;
  logic CLK_SYS = 0, RST_N = 0, SW_REQ = 0, NF_WR = 0, NF_WDATA = 0, TS_CLR = 0, PG_EN = 0, slow = 0;
  logic MEM_ACK, MEM_REQ, MEM_WE, MEM_LOCK, SW_DONE, NESTED_TASK_FLAG, TASK_SWITCHED_FLAG, PHYS_DIRECT;
  logic [1:0]  SW_CAUSE = 0, SW_FAULT;
  logic [15:0] SW_TARGET_SEL = 0, CUR_TASK_SEL;
  logic [31:0] SW_NEW_REC_BASE = 0, SW_NEW_DESC_ADDR = 0, SW_OLD_DESC_ADDR = 0, SW_OLD_REC_BASE = 0;
  logic [31:0] SW_SAVED_FLAGS = 0, LIN_ADDR = 0, MEM_ADDR, MEM_WDATA, MEM_RDATA, PAGE_DIR_BASE, PHYS_ADDR;
  logic [31:0] pdb [3], img [3], dw [3], lk [3];
  logic [51:0] expq [$];
  logic [51:0] e;
  logic [31:0] la;
  logic        nf = 0, ts = 0;
  int          seed = 65622, error_cnt = 0, checks = 0, cur = 0;
  tlb_task_link_busy_tracker u_dut (.*);
  tlb_mem_model u_mem (.clk(CLK_SYS), .rst_n(RST_N), .req(MEM_REQ), .we(MEM_WE), .addr(MEM_ADDR),
    .wdata(MEM_WDATA), .slow(slow), .ack(MEM_ACK), .rdata(MEM_RDATA));
  always #20 CLK_SYS = ~CLK_SYS;
  function automatic logic [31:0] rec(int i); return 32'(i) << 10; endfunction : rec
  function automatic logic [31:0] dsc(int i); return 32'h3000 + 32'(i) * 32'h8; endfunction : dsc
  function automatic logic [15:0] sel(int i); return 16'(i) * 16'h8; endfunction : sel
  task stop_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // *******************************
  // one switch request, expectations noted
  // *******************************
  task sw(input logic [1:0] c, input int n, input logic [1:0] f);
    logic [31:0] r;
    int k;
    r = $random(seed);
    SW_CAUSE <= c;
    SW_TARGET_SEL <= sel(n);
    SW_NEW_REC_BASE <= rec(n);
    SW_NEW_DESC_ADDR <= dsc(n);
    SW_OLD_REC_BASE <= rec(cur);
    SW_OLD_DESC_ADDR <= dsc(cur);
    SW_SAVED_FLAGS <= r;
    SW_REQ <= 1'b1;
    if (f == tlb_pkg::FLT_NONE) begin
      img[cur] = (c == tlb_pkg::CAUSE_RETURN) ? r & ~NB : r;
      if (c != tlb_pkg::CAUSE_CALL) dw[cur] &= ~BB;
      if (c != tlb_pkg::CAUSE_RETURN) dw[n] |= BB;
      if (c == tlb_pkg::CAUSE_CALL) lk[n] = {16'h0, sel(cur)};
      nf = (c == tlb_pkg::CAUSE_CALL) | img[n][tlb_pkg::NESTED_BIT];
      ts = 1'b1;
      cur = n;
    end
    expq.push_back({f, sel(cur), pdb[cur], nf, ts});
    @(posedge CLK_SYS);
    SW_REQ <= 1'b0;
    for (k = 0; k < 400; k++) begin
      @(negedge CLK_SYS);
      if (SW_DONE === 1'b1) break;
    end
    if (k == 400) begin
      error_cnt++;
      stop_test();
    end
    @(posedge CLK_SYS);
    for (int i = 0; i < 3; i++) begin
      `CHK(u_mem.mem[(dsc(i) + tlb_pkg::OFS_DESC_HI) >> 2], dw[i])
      `CHK(u_mem.mem[(rec(i) + tlb_pkg::OFS_FLAGS) >> 2], img[i])
      `CHK(u_mem.mem[rec(i) >> 2], lk[i])
    end
    $display("switch cause %0d to task %0d done", c, n);
  endtask : sw
  always @(negedge CLK_SYS) begin
    if (SW_DONE === 1'b1) begin
      e = expq.size() > 0 ? expq.pop_front() : '1;
      `CHK({SW_FAULT, CUR_TASK_SEL, PAGE_DIR_BASE, NESTED_TASK_FLAG, TASK_SWITCHED_FLAG}, e)
    end
  end
  // *******************************
  // main sequence
  // *******************************
  initial begin
    repeat (2) @(posedge CLK_SYS);
    for (int i = 0; i < 3; i++) begin
      pdb[i] = $random(seed);
      img[i] = $random(seed);
      dw[i] = ($random(seed) & ~BB) | (i == 0 ? BB : 32'h0);
      lk[i] = 32'h0;
      // records change only while no switch runs
      u_mem.mem[(rec(i) + tlb_pkg::OFS_PDB) >> 2] = pdb[i];
      u_mem.mem[(rec(i) + tlb_pkg::OFS_FLAGS) >> 2] = img[i];
      u_mem.mem[(dsc(i) + tlb_pkg::OFS_DESC_HI) >> 2] = dw[i];
    end
    repeat (6) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    @(posedge CLK_SYS);
    sw(tlb_pkg::CAUSE_JUMP, 1, tlb_pkg::FLT_NONE);
    slow <= 1'b1;
    sw(tlb_pkg::CAUSE_CALL, 2, tlb_pkg::FLT_NONE);
    slow <= 1'b0;
    sw(tlb_pkg::CAUSE_CALL, 1, tlb_pkg::FLT_PROT);
    sw(tlb_pkg::CAUSE_CALL, 2, tlb_pkg::FLT_PROT);
    sw(tlb_pkg::CAUSE_RETURN, 1, tlb_pkg::FLT_NONE);
    for (int k = 0; k < 2; k++) begin
      NF_WR <= 1'b1;
      NF_WDATA <= k[0];
      TS_CLR <= 1'b1;
      @(posedge CLK_SYS);
      NF_WR <= 1'b0;
      TS_CLR <= 1'b0;
      nf = k[0];
      ts = 1'b0;
      @(negedge CLK_SYS);
      `CHK({NESTED_TASK_FLAG, TASK_SWITCHED_FLAG}, {nf, ts})
      @(posedge CLK_SYS);
    end
    $display("software flag writes done");
    for (int k = 0; k < 12; k++) begin
      la = $random(seed);
      PG_EN <= (k >= 4 && k < 8);
      LIN_ADDR <= la;
      @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      `CHK(PHYS_ADDR, la)
      if (k == 6 || k == 11) `CHK(PHYS_DIRECT, k == 11)
      @(posedge CLK_SYS);
    end
    $display("address map done");
    for (int j = 0; j < 6; j++) begin
      slow <= 1'($random(seed));
      sw(tlb_pkg::CAUSE_JUMP, (cur + 1 + j % 2) % 3, tlb_pkg::FLT_NONE);
    end
    sw(tlb_pkg::CAUSE_RETURN, 0, tlb_pkg::FLT_REC);
    stop_test();
  end
endmodule : testbench
